/* shared/hcd_pkg.sv */
// Package for the Hall commutation decoder: modes, field widths, reset values.
// Assumes a single 20 MHz clock domain and a plain register port.
package hcd_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned ADDR_W        = 4;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned PAT_W         = 3;
   localparam int unsigned MC_W          = 16;
   // Register offsets (byte addresses)
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_HALL_SH   = 4'h4;
   localparam logic [3:0]  OFS_MC_SH     = 4'h8;
   localparam logic [3:0]  OFS_STATUS    = 4'hc;
   // Control field positions
   localparam int unsigned CTRL_FUNCTION_SELECT_LSB = 0;
   localparam int unsigned CTRL_TWO_HALL = 2;
   localparam int unsigned CTRL_TRIG_SEL = 3;
   localparam int unsigned CTRL_SYNC_LSB = 4;
   localparam int unsigned CTRL_MC_REQ   = 6;
   localparam int unsigned CTRL_HALL_LOAD = 7;
   localparam int unsigned HALL_EXP_LSB  = 3;
   // Reset values
   localparam logic [1:0]  FUNCTION_SELECT_RST      = 2'h0;
   localparam logic [2:0]  PAT_RST       = 3'h0;
   localparam logic [15:0] MC_RST        = 16'h0000;

   typedef enum logic [1:0] {
      HCD_MODE_HALL   = 2'h0,
      HCD_MODE_QUAD   = 2'h1,
      HCD_MODE_MC     = 2'h2,
      HCD_MODE_MCQUAD = 2'h3
   } hcd_mode_t;

   // Event lines toward the timer and PWM slices
   typedef struct packed {
      logic edge_detect_pulse;
      logic correct_event_line;
      logic wrong_event_line;
      logic stop_request_line;
      logic service_request;
   } hcd_events_t;
endpackage

/* hdl/hcd_top.sv */
// Hall commutation decoder with multi-channel pattern output.
// Assumes Hall pins and trigger inputs are asynchronous; register port is synchronous.
`timescale 1ns/10ps
`default_nettype none
module hcd_top (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic [hcd_pkg::ADDR_W-1:0]    addr,
   input  wire logic [hcd_pkg::DATA_W-1:0]    wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic      [hcd_pkg::DATA_W-1:0]    rdata,
   input  wire logic [2:0]                    hall_in,
   input  wire logic [1:0]                    delayed_sample_trigger_inputs,
   input  wire logic [3:0]                    pattern_update_sync,
   output hcd_pkg::hcd_events_t               events,
   output logic                               pattern_update_request,
   output logic      [hcd_pkg::MC_W-1:0]      channel_pattern_bus
);
   // Control and shadow registers
   logic [1:0]  function_select_q;
   logic        two_hall_q;
   logic        trig_sel_q;
   logic [1:0]  sync_sel_q;
   logic [2:0]  current_hall_pattern_q, expected_hall_pattern_q;
   logic [2:0]  current_hall_pattern_shadow_q, expected_hall_pattern_shadow_q;
   logic [15:0] multichannel_pattern_shadow_q;
   logic [2:0]  last_sample_q;
   logic        glitch_seen_q, wrong_seen_q;
   // Synchronisers
   logic [2:0]  hall_s1_q, hall_s2_q, hall_prev_q;
   logic [1:0]  trg_s1_q, trg_s2_q, trg_prev_q;
   logic [3:0]  sync_s1_q, sync_s2_q;
   logic [2:0]  sample_d;
   logic        hall_mode, hall_ready_trigger, multichannel_update_trigger;
   logic        is_glitch, is_correct;
   logic        hall_load;

   // Mask off third sensor in two-sensor topology
   function automatic logic [2:0] hcd_mask(input logic [2:0] p, input logic two);
      hcd_mask = two ? {1'b0, p[1:0]} : p;
   endfunction

   // Two-flop synchronisers for all pin inputs
   always_ff @(posedge clk) begin
      if (rst) begin
         hall_s1_q <= 3'h0;
         hall_s2_q <= 3'h0;
         trg_s1_q  <= 2'h0;
         trg_s2_q  <= 2'h0;
         sync_s1_q <= 4'h0;
         sync_s2_q <= 4'h0;
      end else begin
         hall_s1_q <= hall_in;
         hall_s2_q <= hall_s1_q;
         trg_s1_q  <= delayed_sample_trigger_inputs;
         trg_s2_q  <= trg_s1_q;
         sync_s1_q <= pattern_update_sync;
         sync_s2_q <= sync_s1_q;
      end
   end

   // Edge history after synchronisation
   always_ff @(posedge clk) begin
      if (rst) begin
         hall_prev_q <= 3'h0;
         trg_prev_q  <= 2'h0;
      end else begin
         hall_prev_q <= hall_s2_q;
         trg_prev_q  <= trg_s2_q;
      end
   end

   assign hall_mode = (function_select_q == hcd_pkg::HCD_MODE_HALL);
   // Rising edge of selected delayed trigger starts verification
   assign hall_ready_trigger = hall_mode && trg_s2_q[trig_sel_q]
                               && !trg_prev_q[trig_sel_q];
   assign sample_d   = hcd_mask(hall_s2_q, two_hall_q);
   assign is_glitch  = (sample_d == current_hall_pattern_q);
   assign is_correct = !is_glitch && (sample_d == expected_hall_pattern_q);
   assign multichannel_update_trigger = pattern_update_request
                                        && sync_s2_q[sync_sel_q];
   // Software copy of both shadows, arms the compare pair before the first event
   assign hall_load = wr && addr == hcd_pkg::OFS_CTRL && wdata[hcd_pkg::CTRL_HALL_LOAD];

   // Event outputs, registered one-cycle pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         events <= '0;
      end else begin
         events.edge_detect_pulse <= hall_mode &&
            (hcd_mask(hall_s2_q, two_hall_q) != hcd_mask(hall_prev_q, two_hall_q));
         events.correct_event_line <= hall_ready_trigger && is_correct;
         events.wrong_event_line   <= hall_ready_trigger && !is_glitch && !is_correct;
         events.stop_request_line  <= hall_ready_trigger && !is_correct;
         events.service_request    <= hall_ready_trigger;
      end
   end

   // Compare patterns reload on correct event
   always_ff @(posedge clk) begin
      if (rst) begin
         current_hall_pattern_q  <= hcd_pkg::PAT_RST;
         expected_hall_pattern_q <= hcd_pkg::PAT_RST;
      end else if ((hall_ready_trigger && is_correct) || hall_load) begin
         current_hall_pattern_q  <= current_hall_pattern_shadow_q;
         expected_hall_pattern_q <= expected_hall_pattern_shadow_q;
      end
   end

   // Sticky status of last verification, set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         last_sample_q <= hcd_pkg::PAT_RST;
         glitch_seen_q <= 1'b0;
         wrong_seen_q  <= 1'b0;
      end else begin
         if (hall_ready_trigger) begin
            last_sample_q <= sample_d;
         end
         if (hall_ready_trigger && is_glitch) begin
            glitch_seen_q <= 1'b1;
         end else if (wr && addr == hcd_pkg::OFS_STATUS && wdata[0]) begin
            glitch_seen_q <= 1'b0;
         end
         if (hall_ready_trigger && !is_glitch && !is_correct) begin
            wrong_seen_q <= 1'b1;
         end else if (wr && addr == hcd_pkg::OFS_STATUS && wdata[1]) begin
            wrong_seen_q <= 1'b0;
         end
      end
   end

   // Software writes to control and shadows
   always_ff @(posedge clk) begin
      if (rst) begin
         function_select_q              <= hcd_pkg::FUNCTION_SELECT_RST;
         two_hall_q                     <= 1'b0;
         trig_sel_q                     <= 1'b0;
         sync_sel_q                     <= 2'h0;
         current_hall_pattern_shadow_q  <= hcd_pkg::PAT_RST;
         expected_hall_pattern_shadow_q <= hcd_pkg::PAT_RST;
         multichannel_pattern_shadow_q  <= hcd_pkg::MC_RST;
      end else if (wr) begin
         unique case (addr)
            hcd_pkg::OFS_CTRL: begin
               function_select_q <= wdata[hcd_pkg::CTRL_FUNCTION_SELECT_LSB +: 2];
               two_hall_q        <= wdata[hcd_pkg::CTRL_TWO_HALL];
               trig_sel_q        <= wdata[hcd_pkg::CTRL_TRIG_SEL];
               sync_sel_q        <= wdata[hcd_pkg::CTRL_SYNC_LSB +: 2];
            end
            hcd_pkg::OFS_HALL_SH: begin
               current_hall_pattern_shadow_q  <= wdata[2:0];
               expected_hall_pattern_shadow_q <= wdata[hcd_pkg::HALL_EXP_LSB +: 3];
            end
            hcd_pkg::OFS_MC_SH: begin
               multichannel_pattern_shadow_q <= wdata[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Update request: set by software or Hall correct event, cleared on the sync trigger
   always_ff @(posedge clk) begin
      if (rst) begin
         pattern_update_request <= 1'b0;
      end else if ((wr && addr == hcd_pkg::OFS_CTRL && wdata[hcd_pkg::CTRL_MC_REQ])
                   || (hall_ready_trigger && is_correct)) begin
         pattern_update_request <= 1'b1;
      end else if (multichannel_update_trigger) begin
         pattern_update_request <= 1'b0;
      end
   end

   // Multi-channel shadow loads the bus on the sync trigger, except in quadrature mode
   always_ff @(posedge clk) begin
      if (rst) begin
         channel_pattern_bus <= hcd_pkg::MC_RST;
      end else if (multichannel_update_trigger
                   && function_select_q != hcd_pkg::HCD_MODE_QUAD) begin
         channel_pattern_bus <= multichannel_pattern_shadow_q;
      end
   end

   // Read port, data valid one cycle after strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         unique case (addr)
            hcd_pkg::OFS_CTRL:    rdata <= {25'h0, pattern_update_request, sync_sel_q,
                                            trig_sel_q, two_hall_q, function_select_q};
            hcd_pkg::OFS_HALL_SH: rdata <= {26'h0, expected_hall_pattern_shadow_q,
                                            current_hall_pattern_shadow_q};
            hcd_pkg::OFS_MC_SH:   rdata <= {16'h0, multichannel_pattern_shadow_q};
            hcd_pkg::OFS_STATUS:  rdata <= {21'h0, last_sample_q, expected_hall_pattern_q,
                                            current_hall_pattern_q, wrong_seen_q,
                                            glitch_seen_q};
            default:              rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // Assertions
   property p_stop_cause;
      @(posedge clk) disable iff (rst)
      events.stop_request_line |-> $past(hall_ready_trigger) && !$past(is_correct);
   endproperty
   a_stop_cause: assert property (p_stop_cause) else $error("stop without cause");
   property p_correct_excl;
      @(posedge clk) disable iff (rst)
      events.correct_event_line |-> !events.wrong_event_line && !events.stop_request_line;
   endproperty
   a_correct_excl: assert property (p_correct_excl) else $error("correct with stop");
   property p_reload;
      @(posedge clk) disable iff (rst)
      (hall_ready_trigger && is_correct) |=>
         current_hall_pattern_q == $past(current_hall_pattern_shadow_q);
   endproperty
   a_reload: assert property (p_reload) else $error("current pattern not reloaded");
   property p_wrong_stop;
      @(posedge clk) disable iff (rst)
      events.wrong_event_line |-> events.stop_request_line && events.service_request;
   endproperty
   a_wrong_stop: assert property (p_wrong_stop) else $error("wrong without stop");
   property p_srv;
      @(posedge clk) disable iff (rst) hall_ready_trigger |=> events.service_request;
   endproperty
   a_srv: assert property (p_srv) else $error("no service request");
   property p_mc_hold;
      @(posedge clk) disable iff (rst)
      !$past(multichannel_update_trigger) |-> $stable(channel_pattern_bus);
   endproperty
   a_mc_hold: assert property (p_mc_hold) else $error("bus changed without trigger");
   property p_no_hall;
      @(posedge clk) disable iff (rst)
      !hall_mode |=> !events.edge_detect_pulse && !events.service_request;
   endproperty
   a_no_hall: assert property (p_no_hall) else $error("Hall event outside Hall mode");
   property p_edge;
      @(posedge clk) disable iff (rst)
      (hall_mode && hall_s2_q != hall_prev_q && !two_hall_q) |=> events.edge_detect_pulse;
   endproperty
   a_edge: assert property (p_edge) else $error("edge missed");
   property p_glitch;
      @(posedge clk) disable iff (rst)
      (hall_ready_trigger && is_glitch) |=>
         events.stop_request_line && !events.wrong_event_line;
   endproperty
   a_glitch: assert property (p_glitch) else $error("glitch not flagged as stop");
   property p_correct_req;
      @(posedge clk) disable iff (rst)
      events.correct_event_line |-> pattern_update_request;
   endproperty
   a_correct_req: assert property (p_correct_req) else $error("correct without request");
   property p_mc_load;
      @(posedge clk) disable iff (rst)
      (multichannel_update_trigger && function_select_q != hcd_pkg::HCD_MODE_QUAD) |=>
         channel_pattern_bus == $past(multichannel_pattern_shadow_q);
   endproperty
   a_mc_load: assert property (p_mc_load) else $error("pattern not loaded");
   property p_quad_hold;
      @(posedge clk) disable iff (rst)
      (function_select_q == hcd_pkg::HCD_MODE_QUAD) |=> $stable(channel_pattern_bus);
   endproperty
   a_quad_hold: assert property (p_quad_hold) else $error("bus loaded in quad mode");
   property p_req_clear;
      @(posedge clk) disable iff (rst)
      (multichannel_update_trigger && !hall_ready_trigger && !wr) |=> !pattern_update_request;
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request not cleared");
   property p_hall_load;
      @(posedge clk) disable iff (rst)
      hall_load |=> expected_hall_pattern_q == $past(expected_hall_pattern_shadow_q);
   endproperty
   a_hall_load: assert property (p_hall_load) else $error("expected not loaded");
   property p_two_hall;
      @(posedge clk) disable iff (rst)
      (two_hall_q && hall_s2_q[1:0] == hall_prev_q[1:0]) |=> !events.edge_detect_pulse;
   endproperty
   a_two_hall: assert property (p_two_hall) else $error("third sensor seen");
   c_correct: cover property (@(posedge clk) disable iff (rst) events.correct_event_line);
   c_wrong:   cover property (@(posedge clk) disable iff (rst) events.wrong_event_line);
   c_mc:      cover property (@(posedge clk) disable iff (rst) multichannel_update_trigger);
   c_glitch:  cover property (@(posedge clk) disable iff (rst) hall_ready_trigger && is_glitch);
   c_load:    cover property (@(posedge clk) disable iff (rst) hall_load);
endmodule
`default_nettype wire

/* test/hcd_timer_model.sv */
// Model of the delay timer and PWM sync source beside the Hall decoder.
// Assumes one clock; the bench picks the trigger input and the sync line.
`timescale 1ns/10ps
`default_nettype none
module hcd_timer_model #(
   parameter int DELAY = 6
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       edge_pulse,
   input  wire logic       sel,
   input  wire logic       update_req,
   input  wire logic [1:0] sync_sel,
   input  wire logic       sync_en,
   output logic      [1:0] trig,
   output logic      [3:0] sync
);
   int cnt_q;
   // Edge starts a one-shot delay, then the chosen trigger stays high 4 cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 0;
         trig  <= 2'h0;
      end else begin
         if (edge_pulse) cnt_q <= DELAY + 4;
         else if (cnt_q != 0) cnt_q <= cnt_q - 1;
         trig <= (cnt_q != 0 && cnt_q <= 4) ? {sel, !sel} : 2'h0;
      end
   end
   // Sync line answers a pending update request when the slices allow
   always_ff @(posedge clk) begin
      sync <= (!rst && sync_en && update_req) ? (4'h1 << sync_sel) : 4'h0;
   end
endmodule
`default_nettype wire

/* test/hall_commutation_decoder_tb.sv */
// Self-checking bench for the Hall commutation decoder.
// Assumes the timer model closes the edge-to-trigger loop.
`timescale 1ns/10ps
`default_nettype none
module hall_commutation_decoder_tb;
   logic                 clk, rst, wr, rd, sel, sync_en;
   logic [3:0]           addr;
   logic [31:0]          wdata, rdata;
   logic [2:0]           hall_in;
   logic [1:0]           trig;
   logic [3:0]           sync;
   logic                 upd_req;
   logic [15:0]          bus;
   hcd_pkg::hcd_events_t ev;
   int                   n_mismatch, checks;

   hcd_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .hall_in(hall_in), .delayed_sample_trigger_inputs(trig),
      .pattern_update_sync(sync), .events(ev), .pattern_update_request(upd_req),
      .channel_pattern_bus(bus));
   hcd_timer_model model (.clk(clk), .rst(rst), .edge_pulse(ev.edge_detect_pulse),
      .sel(sel), .update_req(upd_req), .sync_sel(2'h2), .sync_en(sync_en),
      .trig(trig), .sync(sync));

   // Clock at 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Move the Hall pins and collect which event lines pulse
   task automatic hall_step(input logic [2:0] p, input logic es, ew, ee, ec);
      logic e, s, w, c, v;
      e = 0; s = 0; w = 0; c = 0; v = 0;
      @(posedge clk);
      hall_in <= p;
      repeat (40) begin
         @(posedge clk);
         #1;
         e |= ev.edge_detect_pulse;
         v |= ev.service_request;
         s |= ev.stop_request_line;
         w |= ev.wrong_event_line;
         c |= ev.correct_event_line;
      end
      chk(e, ee);
      chk(s, es);
      chk(w, ew);
      chk(c, ec);
      chk(v, es | ec);
   endtask

   // Wait for the sync handshake to clear the update request
   task automatic mc_wait();
      int n;
      n = 0;
      #1;
      while (upd_req !== 1'b0 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk(upd_req, 1'b0);
   endtask

   task automatic test_hall();
      logic [31:0] d;
      rd_reg(hcd_pkg::OFS_CTRL, d);   chk(d, 32'h0);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d, 32'h0);
      rd_reg(4'h2, d);                chk(d, 32'h0);
      hall_step(3'h5, 1, 1, 1, 0);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d, 32'h502);
      wr_reg(hcd_pkg::OFS_STATUS, 32'h2);
      hall_step(3'h0, 1, 0, 1, 0);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d, 32'h1);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h8);
      hall_step(3'h5, 0, 0, 1, 0);
      sel = 1'b1;
      hall_step(3'h0, 1, 0, 1, 0);
      wr_reg(hcd_pkg::OFS_CTRL, 32'hc);
      hall_step(3'h6, 1, 1, 1, 0);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d[10:8], 32'h2);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h1);
      hall_step(3'h1, 0, 0, 0, 0);
   endtask

   // Software arms the compare pair, then the motor reaches the expected pattern
   task automatic test_correct();
      logic [31:0] d;
      sel = 1'b0;
      wr_reg(hcd_pkg::OFS_STATUS, 32'h3);
      wr_reg(hcd_pkg::OFS_HALL_SH, 32'h19);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h80);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d, 32'h264);
      wr_reg(hcd_pkg::OFS_HALL_SH, 32'h13);
      hall_step(3'h3, 0, 0, 1, 1);
      chk(upd_req, 1'b1);
      rd_reg(hcd_pkg::OFS_STATUS, d); chk(d, 32'h34c);
   endtask

   task automatic test_mc();
      logic [31:0] d;
      wr_reg(hcd_pkg::OFS_CTRL, 32'h22);
      wr_reg(hcd_pkg::OFS_MC_SH, 32'ha5c3);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h62);
      repeat (10) @(posedge clk);
      #1 chk(bus, 32'h0);
      chk(upd_req, 1'b1);
      sync_en = 1'b1;
      mc_wait();
      chk(bus, 32'ha5c3);
      rd_reg(hcd_pkg::OFS_CTRL, d); chk(d[6], 1'b0);
      repeat (5) @(posedge clk);
      #1 chk(bus, 32'ha5c3);
      // Quadrature-only mode clears the request but keeps the pattern
      wr_reg(hcd_pkg::OFS_CTRL, 32'h21);
      wr_reg(hcd_pkg::OFS_MC_SH, 32'h1234);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h61);
      mc_wait();
      chk(bus, 32'ha5c3);
      wr_reg(hcd_pkg::OFS_CTRL, 32'h63);
      mc_wait();
      chk(bus, 32'h1234);
   endtask

   // Watchdog
   initial begin
      #(5000 * 50);
      n_mismatch++;
      test_done();
   end

   initial begin
      n_mismatch = 0; checks = 0;
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
      hall_in = 3'h0; sel = 1'b0; sync_en = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      test_hall();
      test_correct();
      test_mc();
      test_done();
   end
endmodule
`default_nettype wire
